// [design/fcal_map.vh]
`ifndef FCAL_MAP_VH
`define FCAL_MAP_VH

// ***************************************************************
// Clock and timing
// ***************************************************************
`define FCAL_CLK_KHZ        10000
`define FCAL_TC_FAST_MS     150
`define FCAL_TC_FASTER_MS   100
`define FCAL_TC_SLOW_MS     5000
`define FCAL_TC_SLOWER_MS   10000

// ***************************************************************
// Configuration words, digit one in the top nibble
// ***************************************************************
`define FCAL_CFG_W          24
`define FCAL_DIG1_MSB       23
`define FCAL_DIG1_LSB       20
`define FCAL_DIG2_MSB       19
`define FCAL_DIG2_LSB       16
`define FCAL_DIG3_MSB       15
`define FCAL_DIG3_LSB       12
`define FCAL_DIG4_MSB       11
`define FCAL_DIG4_LSB       8
`define FCAL_DIG5_MSB       7
`define FCAL_DIG5_LSB       4
`define FCAL_DIG6_MSB       3
`define FCAL_DIG6_LSB       0
`define FCAL_FLOW_CFG_RST   24'h203400
`define FCAL_OUT_CFG_RST    24'h210100

// ***************************************************************
// Digit codes
// ***************************************************************
`define FCAL_OUT3_PI        4'h1
`define FCAL_OUT2_BATCH     4'h2
`define FCAL_OUT2_LIMIT     4'h4
`define FCAL_OUT2_SIGN      4'h8
`define FCAL_MODE_TEST      4'h8
`define FCAL_DIR_UNI_CUT    4'h0
`define FCAL_DIR_UNI        4'h2
`define FCAL_DIR_BI_CUT     4'h4
`define FCAL_DIR_BI         4'h6
`define FCAL_TEMP_C         4'h2
`define FCAL_TEMP_F         4'h3
`define FCAL_IN1_STOP       4'h2
`define FCAL_IN1_STOP_ERR   4'h3
`define FCAL_IN1_BATCH      4'h4
`define FCAL_ADDR_MIN       8'h01
`define FCAL_ADDR_MAX       8'h7D
`define FCAL_IN1_ERR_CODE   5
`define FCAL_LOWCUT_PERMIL  2

`endif

// [design/fcal_flow_config.v]
`timescale 1ns/1ps
`include "fcal_map.vh"

// Notes on behaviour
// - With output three as PI regulator, output two refuses batch or limit functions.
// - Output two sign mode drives output two high only for positive flow.
// - Test mode ignores measured flow; the flow register takes externally written values.
// - Digit one picks per-minute or per-hour and filter constant 0.15/0.1/5/10 s.
// - Digit two picks direction and 0.2% cutoff; digit three picks Celsius/Fahrenheit.
// - Bidirectional keeps reverse flow negative; unidirectional discards reverse flow.
// - Digit four: input one stops counter, stops with error 05, or clears and batches.
// - Digits five and six form hex node address 01 to 7D, digit five high.
// - Of simultaneous faults, only the highest code number is saved.
// - Stored fault is shown as a two-digit code on a test request.
// - Alarm stays set until its code is read, even after the fault clears.
// - Shown code changes only on a test request; no fault reports zero.
module fcal_flow_config
#(
   parameter FLOW_W      = 24,
   parameter FAULT_N     = 32,
   parameter FULL_SCALE  = 1000000,
   parameter TC_FAST     = `FCAL_TC_FAST_MS * `FCAL_CLK_KHZ,
   parameter TC_FASTER   = `FCAL_TC_FASTER_MS * `FCAL_CLK_KHZ,
   parameter TC_SLOW     = `FCAL_TC_SLOW_MS * `FCAL_CLK_KHZ,
   parameter TC_SLOWER   = `FCAL_TC_SLOWER_MS * `FCAL_CLK_KHZ
)
(
   // Clock and reset
   input  wire                   clock,
   input  wire                   rstn,
   // Configuration access from display unit or fieldbus
   input  wire                   flow_cfg_wr,
   input  wire                   out_cfg_wr,
   input  wire [23:0]            cfg_wdata,
   output reg  [23:0]            flow_function_config_q,
   output reg  [23:0]            output_function_config_q,
   output reg                    cfg_reject_q,
   // Flow path
   input  wire                   meas_valid,
   input  wire signed [FLOW_W-1:0] meas_flow,
   input  wire                   flow_wr,
   input  wire signed [FLOW_W-1:0] flow_wdata,
   output reg  signed [FLOW_W-1:0] flow_q,
   // Decoded settings
   output reg                    per_hour_q,
   output reg  [31:0]            filt_cycles_q,
   output reg                    bidir_q,
   output reg                    fahrenheit_q,
   output reg  [6:0]             node_addr_q,
   output reg                    test_mode_q,
   // Discrete input and outputs
   input  wire                   discrete_input_one,
   output reg                    discrete_output_two,
   output reg                    counter_stop_q,
   output reg                    vol2_clear_q,
   output reg                    batch_start_q,
   // Faults and alarm
   input  wire [FAULT_N-1:0]     fault_in,
   input  wire                   test_req,
   output reg                    alarm_q,
   output reg  [7:0]             err_code_q
);

   // ***************************************************************
   // Digit acceptance tables
   // ***************************************************************

   // A digit that matches no defined entry keeps its old value
   function [3:0] pick;
      input [3:0] new_d;
      input [3:0] old_d;
      input [15:0] legal;
      begin
         pick = legal[new_d] ? new_d : old_d;
      end
   endfunction

   // Highest set fault bit gives the code number
   function [7:0] top_code;
      input [FAULT_N-1:0] f;
      integer i;
      begin
         top_code = 8'h00;
         for (i = 0; i < FAULT_N; i = i + 1)
            if (f[i])
               top_code = i[7:0];
      end
   endfunction

   // Binary code to two BCD digits, codes up to 99
   function [7:0] to_bcd;
      input [7:0] b;
      reg   [7:0] t;
      reg   [7:0] u;
      begin
         t = b / 8'h0A;
         u = b - t * 8'h0A;
         to_bcd = {t[3:0], u[3:0]};
      end
   endfunction

   // ***************************************************************
   // Configuration registers
   // ***************************************************************
   reg  [23:0] flow_cfg_d;
   reg  [23:0] out_cfg_d;
   reg         reject_d;
   wire [7:0]  addr_new = cfg_wdata[`FCAL_DIG5_MSB:`FCAL_DIG6_LSB];
   wire [3:0]  o1_new   = pick(cfg_wdata[23:20],
                               output_function_config_q[23:20], 16'h0017);

   // Each digit is checked on its own, but output digit three clears under a PI digit one; the two address digits stand or fall as one byte
   always @*
   begin
      flow_cfg_d = flow_function_config_q;
      out_cfg_d  = output_function_config_q;
      reject_d   = 1'b0;
      if (flow_cfg_wr)
      begin
         flow_cfg_d[23:20] = pick(cfg_wdata[23:20], flow_function_config_q[23:20],
                                  16'h00FF);
         flow_cfg_d[19:16] = pick(cfg_wdata[19:16], flow_function_config_q[19:16],
                                  16'h0055);
         flow_cfg_d[15:12] = pick(cfg_wdata[15:12], flow_function_config_q[15:12],
                                  16'h000C);
         flow_cfg_d[11:8]  = pick(cfg_wdata[11:8], flow_function_config_q[11:8],
                                  16'h001C);
         if (addr_new >= `FCAL_ADDR_MIN && addr_new <= `FCAL_ADDR_MAX)
            flow_cfg_d[7:0] = addr_new;
         reject_d = (flow_cfg_d != cfg_wdata);
      end
      if (out_cfg_wr)
      begin
         out_cfg_d[23:20] = o1_new;
         out_cfg_d[19:16] = pick(cfg_wdata[19:16], output_function_config_q[19:16],
                                 16'h011F);
         out_cfg_d[15:12] = pick(cfg_wdata[15:12], output_function_config_q[15:12],
                                 16'h0157);
         // PI regulator and setpoint users share one setpoint register
         if (o1_new == `FCAL_OUT3_PI &&
             (out_cfg_d[15:12] == `FCAL_OUT2_BATCH ||
              out_cfg_d[15:12] == `FCAL_OUT2_LIMIT))
            out_cfg_d[15:12] = 4'h0;
         out_cfg_d[11:8] = pick(cfg_wdata[11:8], output_function_config_q[11:8],
                                16'h0107);
         out_cfg_d[7:4]  = pick(cfg_wdata[7:4], output_function_config_q[7:4],
                                16'h0101);
         out_cfg_d[3:0]  = pick(cfg_wdata[3:0], output_function_config_q[3:0],
                                16'h017F);
         reject_d = reject_d | (out_cfg_d != cfg_wdata);
      end
   end

   // Configuration storage and refusal flag
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         flow_function_config_q   <= `FCAL_FLOW_CFG_RST;
         output_function_config_q <= `FCAL_OUT_CFG_RST;
         cfg_reject_q             <= 1'b0;
      end
      else
      begin
         flow_function_config_q   <= flow_cfg_d;
         output_function_config_q <= out_cfg_d;
         cfg_reject_q             <= reject_d;
      end
   end

   // ***************************************************************
   // Decoded settings, registered so every output is a flop
   // ***************************************************************
   wire [3:0] fd1 = flow_cfg_d[23:20];
   wire [3:0] fd2 = flow_cfg_d[19:16];

   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         per_hour_q    <= 1'b0;
         filt_cycles_q <= 32'h0000_0000;
         bidir_q       <= 1'b0;
         fahrenheit_q  <= 1'b0;
         node_addr_q   <= 7'h00;
         test_mode_q   <= 1'b0;
      end
      else
      begin
         per_hour_q <= fd1[0];
         case (fd1[2:1])
            2'b00:   filt_cycles_q <= TC_FAST;
            2'b01:   filt_cycles_q <= TC_FASTER;
            2'b10:   filt_cycles_q <= TC_SLOW;
            default: filt_cycles_q <= TC_SLOWER;
         endcase
         bidir_q      <= fd2[2];
         fahrenheit_q <= (flow_cfg_d[15:12] == `FCAL_TEMP_F);
         node_addr_q  <= flow_cfg_d[6:0];
         test_mode_q  <= (out_cfg_d[7:4] == `FCAL_MODE_TEST);
      end
   end

   // ***************************************************************
   // Flow register
   // ***************************************************************
   // Threshold is worked out in 32 bits, then cut to the flow width on purpose
   localparam integer      LOW_CUT_I = FULL_SCALE * `FCAL_LOWCUT_PERMIL / 1000;
   localparam [FLOW_W-1:0] LOW_CUT   = LOW_CUT_I[FLOW_W-1:0];
   wire              low_cut_on = (fd2 == `FCAL_DIR_UNI_CUT) || (fd2 == `FCAL_DIR_BI_CUT);
   wire [FLOW_W-1:0] meas_mag   = meas_flow[FLOW_W-1] ? -meas_flow : meas_flow;

   // Test mode hands the register to the outside writer instead of the meter
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         flow_q <= {FLOW_W{1'b0}};
      else if (test_mode_q)
      begin
         if (flow_wr)
            flow_q <= flow_wdata;
      end
      else if (meas_valid)
      begin
         if (!fd2[2] && meas_flow[FLOW_W-1])
            flow_q <= {FLOW_W{1'b0}};
         else if (low_cut_on && meas_mag < LOW_CUT)
            flow_q <= {FLOW_W{1'b0}};
         else
            flow_q <= meas_flow;
      end
   end

   // ***************************************************************
   // Discrete input one and output two
   // ***************************************************************
   reg  in1_s1_q;
   reg  in1_s2_q;
   reg  in1_old_q;
   wire [3:0] in1_act = flow_function_config_q[11:8];
   wire in1_rise = in1_s2_q & ~in1_old_q;
   wire in1_err  = in1_s2_q && in1_act == `FCAL_IN1_STOP_ERR;

   // Pin passes two flops before any logic looks at it
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         in1_s1_q            <= 1'b0;
         in1_s2_q            <= 1'b0;
         in1_old_q           <= 1'b0;
         counter_stop_q      <= 1'b0;
         vol2_clear_q        <= 1'b0;
         batch_start_q       <= 1'b0;
         discrete_output_two <= 1'b0;
      end
      else
      begin
         in1_s1_q       <= discrete_input_one;
         in1_s2_q       <= in1_s1_q;
         in1_old_q      <= in1_s2_q;
         counter_stop_q <= in1_s2_q && (in1_act == `FCAL_IN1_STOP ||
                                        in1_act == `FCAL_IN1_STOP_ERR);
         vol2_clear_q   <= in1_rise && in1_act == `FCAL_IN1_BATCH;
         batch_start_q  <= in1_rise && in1_act == `FCAL_IN1_BATCH;
         // Output two serves only the sign function here; others live elsewhere
         discrete_output_two <= (output_function_config_q[15:12] == `FCAL_OUT2_SIGN) &&
                                !flow_q[FLOW_W-1] && (flow_q != 0);
      end
   end

   // ***************************************************************
   // Fault latch and alarm
   // ***************************************************************
   reg  [7:0]         saved_q;
   reg  [FAULT_N-1:0] all_faults;
   reg  [7:0]         now_code;

   // Input one error joins the other faults under its own code
   always @*
   begin
      all_faults = fault_in;
      if (in1_err)
         all_faults[`FCAL_IN1_ERR_CODE] = 1'b1;
      now_code = top_code(all_faults);
   end

   // A fault arriving with the read is kept: set wins over clear
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         saved_q    <= 8'h00;
         alarm_q    <= 1'b0;
         err_code_q <= 8'h00;
      end
      else if (test_req)
      begin
         err_code_q <= to_bcd(alarm_q ? saved_q : now_code);
         saved_q    <= now_code;
         alarm_q    <= (now_code != 8'h00);
      end
      else if (now_code != 8'h00)
      begin
         alarm_q <= 1'b1;
         if (now_code > saved_q)
            saved_q <= now_code;
      end
   end

endmodule

// [tb/fcal_monitor.sv]
`timescale 1ns/1ps
// *****
// Port checker for the flow config block
// *****
module fcal_monitor
#(
   parameter FLOW_W = 24
)
(
   // Clock and reset
   input wire                     clock,
   input wire                     rstn,
   // Requests
   input wire                     flow_cfg_wr,
   input wire                     out_cfg_wr,
   input wire                     meas_valid,
   input wire                     flow_wr,
   input wire                     test_req,
   // Results
   input wire [23:0]              flow_function_config_q,
   input wire [23:0]              output_function_config_q,
   input wire                     cfg_reject_q,
   input wire signed [FLOW_W-1:0] flow_q,
   input wire                     test_mode_q,
   input wire [6:0]               node_addr_q,
   input wire                     discrete_output_two,
   input wire                     alarm_q,
   input wire [7:0]               err_code_q
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   // A refusal can only follow a write
   a_reject_after_write : assert property (cfg_reject_q |-> $past(flow_cfg_wr) || $past(out_cfg_wr))
      else $error("reject flag without a write");
   // Setpoint is never shared between regulator and batch or limit
   a_pi_no_setpoint : assert property (output_function_config_q[23:20] == 4'h1 |->
      output_function_config_q[15:12] != 4'h2 && output_function_config_q[15:12] != 4'h4)
      else $error("regulator with batch or limit on output two");
   // Sign output lags the flow register by one edge
   a_sign_follows : assert property (discrete_output_two ==
      ($past(output_function_config_q[15:12]) == 4'h8 && $past(flow_q) > 0))
      else $error("output two does not follow flow sign");
   a_test_holds_flow : assert property (test_mode_q && !flow_wr |=> $stable(flow_q))
      else $error("flow changed in test mode without a write");
   a_unidir_drops : assert property (meas_valid && !flow_wr && !test_mode_q && !flow_cfg_wr &&
      !flow_function_config_q[18] |=> !flow_q[FLOW_W-1])
      else $error("reverse flow kept in one-direction mode");
   a_node_legal : assert property (node_addr_q <= 7'h7D)
      else $error("node address above range");
   a_err_on_request : assert property (!$past(test_req) |-> $stable(err_code_q))
      else $error("error code moved without a test request");
   a_alarm_sticky : assert property (alarm_q && !test_req |=> alarm_q)
      else $error("alarm dropped before readout");

   c_reject : cover property (cfg_reject_q);
   c_sign_on : cover property (discrete_output_two);
   c_alarm_read : cover property (alarm_q && test_req);
endmodule

// [tb/fcal_display_model.sv]
`timescale 1ns/1ps
// *****
// Display unit: config writes, flow writes, test button
// *****
module fcal_display_model
(
   // Clock
   input  wire        clock,
   // Requests
   output reg         flow_cfg_wr,
   output reg         out_cfg_wr,
   output reg  [23:0] cfg_wdata,
   output reg         flow_wr,
   output reg  [23:0] flow_wdata,
   output reg         test_req
);
   // Idle strobes low; released data shows the inverse so stale values never pass
   initial
   begin
      {flow_cfg_wr, out_cfg_wr, flow_wr, test_req} = 4'h0;
      cfg_wdata = 24'h000000;
      flow_wdata = 24'h000000;
   end

   task cfg_write(input bit sel_out, input [23:0] d);
      @(negedge clock);
      cfg_wdata = d;
      flow_cfg_wr = !sel_out;
      out_cfg_wr = sel_out;
      @(negedge clock);
      {flow_cfg_wr, out_cfg_wr} = 2'h0;
      cfg_wdata = ~d;
   endtask

   task flow_write(input [23:0] v);
      @(negedge clock);
      flow_wr = 1'b1;
      flow_wdata = v;
      @(negedge clock);
      flow_wr = 1'b0;
      flow_wdata = ~v;
   endtask

   task press_test;
      @(negedge clock);
      test_req = 1'b1;
      @(negedge clock);
      test_req = 1'b0;
   endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
// *****
// Self-checking bench
// *****
module tb;
   reg                clock = 1'b0;
   reg                rstn = 1'b0;
   reg                meas_valid = 1'b0;
   reg  signed [23:0] meas_flow = 24'h000000;
   reg                discrete_input_one = 1'b0;
   reg         [31:0] fault_in = 32'h00000000;
   wire flow_cfg_wr, out_cfg_wr, flow_wr, test_req, cfg_reject_q, per_hour_q, bidir_q;
   wire fahrenheit_q, test_mode_q, discrete_output_two, counter_stop_q, vol2_clear_q;
   wire batch_start_q, alarm_q;
   wire        [23:0] cfg_wdata, flow_function_config_q, output_function_config_q, flow_wdata;
   wire signed [23:0] flow_q;
   wire        [31:0] filt_cycles_q;
   wire        [6:0]  node_addr_q;
   wire        [7:0]  err_code_q;
   int                n_mismatch = 0;
   int                comparisons = 0;
   int                cycles = 0;
   int                k;
   int                tc[4] = '{15, 10, 50, 100};
   bit         [31:0] xs = 65;
   reg         [23:0] v;
   logic       [7:0]  exp_q[$];
   reg                tr_d = 1'b0;
   logic       [23:0] dir_cfg[5] = '{24'h403401, 24'h403401, 24'h423401, 24'h443401, 24'h463401};
   logic       [23:0] dir_in[5] = '{24'h1, 24'h2, -24'sd5, -24'sd1, -24'sd1};
   logic       [23:0] dir_out[5] = '{24'h0, 24'h2, 24'h0, 24'h0, -24'sd1};

   always #50 clock = ~clock;

   fcal_display_model i_disp (.clock, .flow_cfg_wr, .out_cfg_wr, .cfg_wdata, .flow_wr,
      .flow_wdata, .test_req);

   // Short filter counts keep the run brief
   fcal_flow_config #(.FULL_SCALE(1000), .TC_FAST(15), .TC_FASTER(10), .TC_SLOW(50),
      .TC_SLOWER(100)) i_dut (.clock, .rstn, .flow_cfg_wr, .out_cfg_wr, .cfg_wdata,
      .flow_function_config_q, .output_function_config_q, .cfg_reject_q, .meas_valid,
      .meas_flow, .flow_wr, .flow_wdata, .flow_q, .per_hour_q, .filt_cycles_q, .bidir_q,
      .fahrenheit_q, .node_addr_q, .test_mode_q, .discrete_input_one, .discrete_output_two,
      .counter_stop_q, .vol2_clear_q, .batch_start_q, .fault_in, .test_req, .alarm_q,
      .err_code_q);

   function bit [31:0] rnd();
      xs ^= xs << 13;
      xs ^= xs >> 17;
      xs ^= xs << 5;
      return xs;
   endfunction

   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task test_done;
      $display("Counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task cyc(input int n);
      repeat (n) @(negedge clock);
   endtask

   // Config write, then stored word and refusal flag in the answering cycle
   task wr_chk(input bit sel, input [23:0] d, input [23:0] e);
      i_disp.cfg_write(sel, d);
      check("cfg_word", sel ? output_function_config_q : flow_function_config_q, e);
      check("cfg_reject", cfg_reject_q, d != e);
   endtask

   task meas(input [23:0] m);
      @(negedge clock);
      meas_valid = 1'b1;
      meas_flow = m;
      @(negedge clock);
      meas_valid = 1'b0;
      meas_flow = ~m;
   endtask

   task test_expect(input [7:0] e);
      exp_q.push_back(e);
      i_disp.press_test;
   endtask

   // Watcher: the code shown after each request against the oldest note
   always @(posedge clock) tr_d <= test_req;
   always @(negedge clock)
      if (tr_d)
         check("err_code", err_code_q, exp_q.pop_front());

   // Hang guard
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         test_done;
      end
   end

   initial
   begin
      cyc(10);
      rstn = 1'b1;
      cyc(2);
      check("flow_cfg", flow_function_config_q, 24'h203400);
      check("filt", filt_cycles_q, 10);
      for (int d = 0; d < 8; d++)
      begin
         wr_chk(0, {d[3:0], 20'h23401}, {d[3:0], 20'h23401});
         cyc(1);
         check("per_hour", per_hour_q, d % 2);
         check("filt", filt_cycles_q, tc[d / 2]);
      end
      // Refused digits keep old values; address digits checked as one byte
      wr_chk(0, 24'h413400, 24'h423401);
      wr_chk(0, 24'h42277D, 24'h42247D);
      cyc(1);
      check("node", node_addr_q, 7'h7D);
      check("fahr", fahrenheit_q, 0);
      wr_chk(0, 24'h42347E, 24'h42347D);
      cyc(1);
      check("node", node_addr_q, 7'h7D);
      check("fahr", fahrenheit_q, 1);
      foreach (dir_cfg[i])
      begin
         wr_chk(0, dir_cfg[i], dir_cfg[i]);
         check("bidir", bidir_q, dir_cfg[i][19:16] >= 4'h4);
         meas(dir_in[i]);
         check("flow", flow_q[23:0], dir_out[i]);
      end
      wr_chk(1, 24'h218100, 24'h218100);
      repeat (4)
      begin
         v = rnd() % 1000 + 2;
         meas(-v);
         check("flow", flow_q[23:0], 24'(-v));
         cyc(1);
         check("out_two", discrete_output_two, 0);
         meas(v);
         cyc(1);
         check("out_two", discrete_output_two, 1);
      end
      wr_chk(1, 24'h112100, 24'h110100);
      wr_chk(1, 24'h114100, 24'h110100);
      wr_chk(1, 24'h210180, 24'h210180);
      check("test", test_mode_q, 1);
      cyc(1);
      meas(24'h000021);
      check("flow", flow_q[23:0], v);
      i_disp.flow_write(24'h000123);
      check("flow", flow_q[23:0], 24'h000123);
      wr_chk(1, 24'h210100, 24'h210100);
      check("test", test_mode_q, 0);
      // Input one actions
      wr_chk(0, 24'h463201, 24'h463201);
      discrete_input_one = 1'b1;
      cyc(4);
      check("stop", counter_stop_q, 1);
      discrete_input_one = 1'b0;
      wr_chk(0, 24'h463401, 24'h463401);
      discrete_input_one = 1'b1;
      cyc(3);
      check("batch", {vol2_clear_q, batch_start_q}, 2'h3);
      cyc(1);
      check("batch", {vol2_clear_q, batch_start_q}, 2'h0);
      discrete_input_one = 1'b0;
      wr_chk(0, 24'h463301, 24'h463301);
      discrete_input_one = 1'b1;
      cyc(5);
      test_expect(8'h05);
      discrete_input_one = 1'b0;
      cyc(4);
      // Input still high at the first read re-arms the alarm: set wins
      test_expect(8'h05);
      test_expect(8'h00);
      // Faults: highest kept, alarm held past the fault
      fault_in = 32'h00000088;
      cyc(2);
      fault_in = 32'h00000000;
      cyc(3);
      check("alarm", alarm_q, 1);
      test_expect(8'h07);
      check("alarm", alarm_q, 0);
      repeat (3)
      begin
         fault_in = rnd() >> (rnd() % 31);
         k = 0;
         for (int b = 1; b < 32; b++)
            if (fault_in[b])
               k = b;
         cyc(2);
         fault_in = 32'h00000000;
         test_expect({4'(k / 10), 4'(k % 10)});
         test_expect(8'h00);
      end
      cyc(2);
      test_done;
   end
endmodule

bind fcal_flow_config fcal_monitor i_mon (.clock, .rstn, .flow_cfg_wr,
   .out_cfg_wr, .meas_valid, .flow_wr, .test_req, .flow_function_config_q,
   .output_function_config_q, .cfg_reject_q, .flow_q, .test_mode_q, .node_addr_q,
   .discrete_output_two, .alarm_q, .err_code_q);
